// file: rtl/msd_defines.svh
`ifndef MSD_DEFINES_SVH
`define MSD_DEFINES_SVH

// register indices; byte address is four times the index
`define MSD_IDX_CFG        8'h00
`define MSD_IDX_STAT       8'h01
`define MSD_IDX_WAIT_CTL   8'ha7
`define MSD_ADDR_W         12

// wait_state_control fields
`define MSD_WAIT_RT_EN     0
`define MSD_WAIT_CLK_EN    1
`define MSD_WAIT_CTL_RST   8'h00

// configuration register fields (user_config_byte_one image)
`define MSD_CFG_MAP_N      0
`define MSD_CFG_PAGE       1
`define MSD_CFG_RST        8'h00

// status register fields
`define MSD_STAT_EA        0
`define MSD_STAT_BUSY      1

// memory map
`define MSD_SEG_TOP        8'hff
`define MSD_SEG_FE         8'hfe
`define MSD_SEG_01         8'h01
`define MSD_SEG_00         8'h00
`define MSD_RAM_BASE       16'h0020
`define MSD_RAM_END        16'h041f
`define MSD_BIT_END        16'h00ff
`define MSD_ALIAS_BASE     16'hc000
`define MSD_ALIAS_CODE_HI  2'b01

// external bus timing
`define MSD_DATA_MIN_CYC   2'd2

`endif

// file: rtl/msd_pkg.sv
package msd_pkg;

   typedef enum logic [1:0]
   {
      MSD_IDLE = 2'b00,
      MSD_ADDR = 2'b01,
      MSD_DATA = 2'b11,
      MSD_DONE = 2'b10
   } msd_bus_state_t;

   function automatic logic msd_in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
      msd_in_range = (v >= lo) && (v <= hi);
   endfunction

endpackage

// file: rtl/msd_pc_wrap.sv
`include "msd_defines.svh"

// next program counter after an increment, with the segment wrap cases
module msd_pc_wrap
   import msd_pkg::*;
(
   input  wire logic [23:0] pc_cur,
   output logic      [23:0] pc_inc
);
   wire logic [15:0] off_end = 16'hffff;
   wire logic        at_end  = (pc_cur[15:0] == off_end);
   wire logic [23:0] plus1   = pc_cur + 24'h000001;

   always_comb
   begin
      pc_inc = plus1;
      if (at_end && (pc_cur[23:16] == `MSD_SEG_TOP))
         pc_inc = {`MSD_SEG_TOP, 16'h0000};
      else if (at_end && (pc_cur[23:16] == `MSD_SEG_FE))
         pc_inc = {`MSD_SEG_TOP, 16'h0000};
      else if (at_end && (pc_cur[23:16] == `MSD_SEG_01))
         pc_inc = {`MSD_SEG_00, 16'h0000};
   end
endmodule

// file: rtl/msd_wait_clk.sv
// oscillator divided by two while enabled, low otherwise
module msd_wait_clk
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic enable,
   output logic      wclk
);
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         wclk <= 1'b0;
      else
         wclk <= enable ? ~wclk : 1'b0;
   end
endmodule

// file: rtl/msd_top.sv
// The AHB-Lite slave port is this design's own decision.
`include "msd_defines.svh"

module msd_top
   import msd_pkg::*;
(
   input  wire logic        REF_CLK,
   input  wire logic        RESET_N,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   input  wire logic        EXT_ACCESS_SELECT_N,
   input  wire logic        WAIT_REQUEST_N,
   output logic             WAIT_CLK,
   input  wire logic        REQ_VALID,
   input  wire logic [23:0] REQ_ADDR,
   input  wire logic        REQ_CODE,
   input  wire logic        REQ_WRITE,
   input  wire logic [7:0]  REQ_WDATA,
   output logic             REQ_READY,
   output logic             RSP_VALID,
   output logic             TGT_CODE,
   output logic             TGT_RAM,
   output logic             TGT_REGF,
   output logic             TGT_BIT,
   output logic             TGT_EXT,
   output logic      [23:0] TGT_ADDR,
   output logic             EXT_DONE,
   output logic      [7:0]  EXT_RDATA,
   input  wire logic        PC_INC,
   input  wire logic [23:0] PC_CUR,
   output logic      [23:0] PC_NEXT,
   input  wire logic [7:0]  LOW_ADDR_PORT_IN,
   output logic      [7:0]  LOW_ADDR_PORT_OUT,
   output logic             LOW_ADDR_PORT_OE,
   input  wire logic [7:0]  HIGH_ADDR_PORT_IN,
   output logic      [7:0]  HIGH_ADDR_PORT_OUT,
   output logic             HIGH_ADDR_PORT_OE
);
   // register bus
   logic [7:0]  wait_state_control_reg;
   logic [7:0]  cfg_reg;
   logic        wr_pend_reg;
   logic [9:0]  wr_idx_reg;
   wire  logic  ahb_take = HSEL && HREADY && HTRANS[1];
   wire  logic [9:0] ahb_idx = HADDR[11:2];

   // pin synchronisers
   logic        ext_sel_s1;
   logic        ext_sel_s2;
   logic        wait_s1;
   logic        wait_s2;
   logic [7:0]  low_port_s1;
   logic [7:0]  low_port_s2;
   logic [7:0]  high_port_s1;
   logic [7:0]  high_port_s2;

   // decode
   logic        ready_reg;
   msd_bus_state_t state_reg;
   msd_bus_state_t state_next;
   logic [1:0]  cnt_reg;
   logic [23:0] bus_addr_reg;
   logic        bus_wr_reg;
   logic [7:0]  bus_wd_reg;
   logic [23:0] pc_wrapped;
   logic        wr_hold_reg;
   logic [7:0]  wd_hold_reg;

   wire  logic        onchip_en = ext_sel_s2;
   wire  logic        realtime_wait_enable = wait_state_control_reg[`MSD_WAIT_RT_EN];
   wire  logic        map_n     = cfg_reg[`MSD_CFG_MAP_N];
   wire  logic        page      = cfg_reg[`MSD_CFG_PAGE];
   wire  logic        accept    = REQ_VALID && ready_reg;
   wire  logic [7:0]  seg       = REQ_ADDR[23:16];
   wire  logic [15:0] off       = REQ_ADDR[15:0];
   wire  logic        seg00     = (seg == `MSD_SEG_00);
   wire  logic        code_int  = onchip_en && (seg == `MSD_SEG_TOP) && !off[15];
   wire  logic        ram_hit   = !REQ_CODE && seg00 && msd_in_range(off, `MSD_RAM_BASE, `MSD_RAM_END);
   wire  logic        regf_hit  = !REQ_CODE && seg00 && (off < `MSD_RAM_BASE);
   wire  logic        bit_hit   = ram_hit && msd_in_range(off, `MSD_RAM_BASE, `MSD_BIT_END);
   wire  logic        alias_hit = !REQ_CODE && seg00 && (off >= `MSD_ALIAS_BASE) && !map_n;
   wire  logic        code_hit  = REQ_CODE ? code_int : (alias_hit && onchip_en);
   wire  logic        ext_hit   = !(code_hit || ram_hit || regf_hit);
   wire  logic [23:0] xl_addr   = alias_hit ? {`MSD_SEG_TOP, `MSD_ALIAS_CODE_HI, off[13:0]} : REQ_ADDR;
   wire  logic        cnt_done  = (cnt_reg == `MSD_DATA_MIN_CYC);
   wire  logic        wait_ok   = !realtime_wait_enable || wait_s2;
   wire  logic        start_bus = RSP_VALID && TGT_EXT;
   wire  logic [23:0] a_src     = (state_reg == MSD_IDLE) ? TGT_ADDR : bus_addr_reg;
   wire  logic        w_src     = (state_reg == MSD_IDLE) ? wr_hold_reg : bus_wr_reg;
   wire  logic [7:0]  d_src     = (state_reg == MSD_IDLE) ? wd_hold_reg : bus_wd_reg;
   wire  logic        ready_next = (state_next == MSD_IDLE) && !accept && !start_bus;

   always_ff @(posedge REF_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         ext_sel_s1   <= 1'b0;
         ext_sel_s2   <= 1'b0;
         wait_s1      <= 1'b0;
         wait_s2      <= 1'b0;
         low_port_s1  <= 8'h00;
         low_port_s2  <= 8'h00;
         high_port_s1 <= 8'h00;
         high_port_s2 <= 8'h00;
      end
      else
      begin
         ext_sel_s1   <= EXT_ACCESS_SELECT_N;
         ext_sel_s2   <= ext_sel_s1;
         wait_s1      <= WAIT_REQUEST_N;
         wait_s2      <= wait_s1;
         low_port_s1  <= LOW_ADDR_PORT_IN;
         low_port_s2  <= low_port_s1;
         high_port_s1 <= HIGH_ADDR_PORT_IN;
         high_port_s2 <= high_port_s1;
      end
   end

   // ahb-lite slave: zero wait states, always okay, unmapped reads zero
   wire  logic [31:0] rd_word =
      (ahb_idx == {2'b00, `MSD_IDX_WAIT_CTL}) ? {24'h000000, wait_state_control_reg} :
      (ahb_idx == {2'b00, `MSD_IDX_CFG})  ? {24'h000000, cfg_reg} :
      (ahb_idx == {2'b00, `MSD_IDX_STAT}) ? {30'h0, (state_reg != MSD_IDLE), onchip_en} : 32'h00000000;

   always_ff @(posedge REF_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         HRDATA      <= 32'h00000000;
         HREADYOUT   <= 1'b1;
         HRESP       <= 1'b0;
         wr_pend_reg <= 1'b0;
         wr_idx_reg  <= 10'h000;
      end
      else
      begin
         wr_pend_reg <= ahb_take && HWRITE;
         wr_idx_reg  <= ahb_idx;
         if (ahb_take && !HWRITE)
            HRDATA <= rd_word;
      end
   end

   always_ff @(posedge REF_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         wait_state_control_reg <= `MSD_WAIT_CTL_RST;
         cfg_reg  <= `MSD_CFG_RST;
      end
      else if (wr_pend_reg && (wr_idx_reg == {2'b00, `MSD_IDX_WAIT_CTL}))
         wait_state_control_reg <= HWDATA[7:0];
      else if (wr_pend_reg && (wr_idx_reg == {2'b00, `MSD_IDX_CFG}))
         cfg_reg <= HWDATA[7:0];
   end

   // wait clock divider
   msd_wait_clk u_wclk
   (
      .clk    (REF_CLK),
      .rst_n  (RESET_N),
      .enable (wait_state_control_reg[`MSD_WAIT_CLK_EN]),
      .wclk   (WAIT_CLK)
   );

   // program counter increment
   msd_pc_wrap u_pc
   (
      .pc_cur (PC_CUR),
      .pc_inc (pc_wrapped)
   );

   always_ff @(posedge REF_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         PC_NEXT <= {`MSD_SEG_TOP, 16'h0000};
      else if (PC_INC)
         PC_NEXT <= pc_wrapped;
   end

   // decode response, one cycle after acceptance
   always_ff @(posedge REF_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         RSP_VALID   <= 1'b0;
         TGT_CODE    <= 1'b0;
         TGT_RAM     <= 1'b0;
         TGT_REGF    <= 1'b0;
         TGT_BIT     <= 1'b0;
         TGT_EXT     <= 1'b0;
         TGT_ADDR    <= 24'h000000;
         wr_hold_reg <= 1'b0;
         wd_hold_reg <= 8'h00;
      end
      else
      begin
         RSP_VALID <= accept;
         if (accept)
         begin
            TGT_CODE    <= code_hit;
            TGT_RAM     <= ram_hit;
            TGT_REGF    <= regf_hit;
            TGT_BIT     <= bit_hit;
            TGT_EXT     <= ext_hit;
            TGT_ADDR    <= xl_addr;
            wr_hold_reg <= REQ_WRITE;
            wd_hold_reg <= REQ_WDATA;
         end
      end
   end

   // external bus cycle
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         MSD_IDLE: if (start_bus) state_next = MSD_ADDR;
         MSD_ADDR: state_next = MSD_DATA;
         MSD_DATA: if (cnt_done && wait_ok) state_next = MSD_DONE;
         MSD_DONE: state_next = MSD_IDLE;
         default:  state_next = MSD_IDLE;
      endcase
   end

   wire  logic in_data = (state_next == MSD_DATA);
   wire  logic in_bus  = (state_next != MSD_IDLE);
   wire  logic [7:0] low_port_next  = (in_data && !page) ? d_src : (in_bus ? a_src[7:0] : 8'h00);
   wire  logic       low_oe_next    = in_data ? (page || w_src) : (in_bus && (page || state_next == MSD_ADDR));
   wire  logic [7:0] high_port_next = (in_data && page) ? d_src : (in_bus ? a_src[15:8] : 8'h00);
   wire  logic       high_oe_next   = in_data ? (!page || w_src) : (in_bus && (!page || state_next == MSD_ADDR));

   always_ff @(posedge REF_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         state_reg          <= MSD_IDLE;
         cnt_reg            <= 2'b00;
         bus_addr_reg       <= 24'h000000;
         bus_wr_reg         <= 1'b0;
         bus_wd_reg         <= 8'h00;
         ready_reg          <= 1'b0;
         REQ_READY          <= 1'b0;
         EXT_DONE           <= 1'b0;
         EXT_RDATA          <= 8'h00;
         LOW_ADDR_PORT_OUT  <= 8'h00;
         LOW_ADDR_PORT_OE   <= 1'b0;
         HIGH_ADDR_PORT_OUT <= 8'h00;
         HIGH_ADDR_PORT_OE  <= 1'b0;
      end
      else
      begin
         state_reg          <= state_next;
         ready_reg          <= ready_next;
         REQ_READY          <= ready_next;
         cnt_reg            <= (state_reg == MSD_DATA && !cnt_done) ? cnt_reg + 2'b01 :
                               (state_reg == MSD_DATA) ? cnt_reg : 2'b00;
         EXT_DONE           <= (state_next == MSD_DONE);
         LOW_ADDR_PORT_OUT  <= low_port_next;
         LOW_ADDR_PORT_OE   <= low_oe_next;
         HIGH_ADDR_PORT_OUT <= high_port_next;
         HIGH_ADDR_PORT_OE  <= high_oe_next;
         if (state_reg == MSD_IDLE && start_bus)
         begin
            bus_addr_reg <= TGT_ADDR;
            bus_wr_reg   <= wr_hold_reg;
            bus_wd_reg   <= wd_hold_reg;
         end
         if (state_next == MSD_DONE)
            EXT_RDATA <= page ? high_port_s2 : low_port_s2;
      end
   end

   // checks
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);

   property p_code_onchip;
      accept && REQ_CODE && onchip_en && REQ_ADDR[23:16] == 8'hff && !REQ_ADDR[15] |=> TGT_CODE && !TGT_EXT;
   endproperty
   a_code_onchip: assert property (p_code_onchip) else $error("on-chip code not selected");

   property p_code_sel_low;
      accept && REQ_CODE && !onchip_en |=> TGT_EXT && !TGT_CODE;
   endproperty
   a_code_sel_low: assert property (p_code_sel_low) else $error("code not sent external");

   property p_pc_wrap;
      PC_INC && PC_CUR[15:0] == 16'hffff && (PC_CUR[23:16] == 8'hff || PC_CUR[23:16] == 8'hfe)
         |=> PC_NEXT == 24'hff0000;
   endproperty
   a_pc_wrap: assert property (p_pc_wrap) else $error("pc did not wrap to reset address");

   property p_pc_low;
      PC_INC && PC_CUR == 24'h01ffff |=> PC_NEXT == 24'h000000;
   endproperty
   a_pc_low: assert property (p_pc_low) else $error("pc did not wrap to segment zero");

   property p_const_top;
      accept && REQ_CODE && onchip_en && REQ_ADDR[23:3] == 21'h1fefff |=> !TGT_EXT ##1 state_reg == MSD_IDLE;
   endproperty
   a_const_top: assert property (p_const_top) else $error("top bytes caused port cycle");

   property p_ram;
      accept && !REQ_CODE && REQ_ADDR >= 24'h000020 && REQ_ADDR <= 24'h00041f
         |=> TGT_RAM && (TGT_BIT == ($past(REQ_ADDR) <= 24'h0000ff));
   endproperty
   a_ram: assert property (p_ram) else $error("ram window or bit area wrong");

   property p_no_code_ram;
      accept && REQ_CODE |=> !TGT_RAM;
   endproperty
   a_no_code_ram: assert property (p_no_code_ram) else $error("code access hit data ram");

   property p_alias;
      accept && !REQ_CODE && REQ_ADDR[23:14] == 10'h003 && !map_n
         |=> TGT_ADDR == {10'h3fd, $past(REQ_ADDR[13:0])}
             && TGT_CODE == $past(onchip_en) && TGT_EXT != $past(onchip_en);
   endproperty
   a_alias: assert property (p_alias) else $error("code alias in region zero wrong");

   property p_alias_off;
      accept && !REQ_CODE && REQ_ADDR[23:14] == 10'h003 && map_n |=> TGT_EXT && !TGT_CODE;
   endproperty
   a_alias_off: assert property (p_alias_off) else $error("code reachable with map bit set");

   property p_data_ext;
      accept && !REQ_CODE && REQ_ADDR[23:16] != 8'h00 |=> TGT_EXT ##1 state_reg == MSD_ADDR;
   endproperty
   a_data_ext: assert property (p_data_ext) else $error("unmapped data not external");

   property p_no_wait;
      !realtime_wait_enable && state_reg == MSD_ADDR |=> state_reg == MSD_DATA [*3] ##1 state_reg == MSD_DONE;
   endproperty
   a_no_wait: assert property (p_no_wait) else $error("bus cycle length wrong");

   property p_stall;
      state_reg == MSD_DATA && cnt_done && realtime_wait_enable && !wait_s2
         |=> state_reg == MSD_DATA && !EXT_DONE;
   endproperty
   a_stall: assert property (p_stall) else $error("not-ready did not stretch cycle");

   property p_wclk;
      $past(wait_state_control_reg[1]) && $past(wait_state_control_reg[1], 2) |-> WAIT_CLK != $past(WAIT_CLK);
   endproperty
   a_wclk: assert property (p_wclk) else $error("wait clock not toggling");

   property p_page;
      page && state_reg == MSD_DATA |-> LOW_ADDR_PORT_OE && LOW_ADDR_PORT_OUT == bus_addr_reg[7:0];
   endproperty
   a_page: assert property (p_page) else $error("page mode port 0 lost address");

   c_ext_done: cover property (EXT_DONE);
   c_stall: cover property (state_reg == MSD_DATA && cnt_done && !wait_ok);
   c_alias: cover property (RSP_VALID && TGT_CODE && TGT_ADDR[23:14] == 10'h3fd);
endmodule

// file: verif/msd_ext_mem_model.sv
// external memory system on the far side of ports 0 and 2
module msd_ext_mem_model
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [3:0] stall,
   input  wire logic [7:0] low_out,
   input  wire logic       low_oe,
   input  wire logic [7:0] high_out,
   input  wire logic       high_oe,
   output logic      [7:0] low_in,
   output logic      [7:0] high_in,
   output logic            wait_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] addr_reg;
   logic [3:0]  cnt_reg;
   logic [7:0]  last_lo_reg;
   logic        both_reg;
   wire         both    = low_oe && high_oe;
   wire         data_lo = !low_oe && high_oe;
   wire         data_hi = low_oe && !high_oe;
   wire  [7:0]  rd      = addr_reg[7:0] ^ addr_reg[15:8] ^ 8'h5a;
   // port 0 floats when released, port 2 has pull-ups
   assign low_in  = low_oe ? low_out : (data_lo ? rd : ~last_lo_reg);
   assign high_in = high_oe ? high_out : (data_hi ? rd : 8'hff);
   assign wait_n  = (cnt_reg == 4'h0);
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         addr_reg    <= 16'h0000;
         cnt_reg     <= 4'h0;
         last_lo_reg <= 8'h00;
         both_reg    <= 1'b0;
      end
      else
      begin
         both_reg    <= both;
         last_lo_reg <= low_in;
         // address is latched only on entry into the address phase
         if (both && !both_reg)
         begin
            addr_reg <= {high_out, low_out};
            cnt_reg  <= stall;
         end
         else if (cnt_reg != 4'h0)
            cnt_reg <= cnt_reg - 4'h1;
      end
   end
endmodule

// file: verif/memory_space_decoder_tb.sv
module memory_space_decoder_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        REF_CLK, RESET_N, HSEL, HWRITE, EXT_SEL_N, REQ_VALID, REQ_CODE, REQ_WRITE, PC_INC;
   logic [31:0] HADDR, HWDATA;
   logic [1:0]  HTRANS;
   logic [2:0]  HSIZE;
   logic [23:0] REQ_ADDR, PC_CUR;
   logic [7:0]  REQ_WDATA;
   logic [3:0]  stall;
   wire  [31:0] HRDATA;
   wire         HREADY, HRESP, WAIT_N, WAIT_CLK, REQ_READY, RSP_VALID, EXT_DONE;
   wire         T_CODE, T_RAM, T_REGF, T_BIT, T_EXT, LO_OE, HI_OE;
   wire  [23:0] TGT_ADDR, PC_NEXT;
   wire  [7:0]  EXT_RDATA, LO_IN, LO_OUT, HI_IN, HI_OUT;
   int          n_errors, checks_done, seed;
   logic [24:0] corner [13] = '{{1'b1, 24'hff7fff}, {1'b1, 24'hff7ff8}, {1'b1, 24'hff8000},
      {1'b0, 24'h00001f}, {1'b0, 24'h000020}, {1'b0, 24'h0000ff}, {1'b0, 24'h000100},
      {1'b0, 24'h00041f}, {1'b0, 24'h000420}, {1'b0, 24'h00bfff}, {1'b0, 24'h00c000},
      {1'b0, 24'h00ffff}, {1'b1, 24'h000020}};
   logic [7:0]  segs [4] = '{8'h00, 8'h01, 8'hfe, 8'hff};

   msd_top u_msd_top (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
      .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
      .HREADYOUT(HREADY), .HRESP(HRESP), .EXT_ACCESS_SELECT_N(EXT_SEL_N), .WAIT_REQUEST_N(WAIT_N),
      .WAIT_CLK(WAIT_CLK), .REQ_VALID(REQ_VALID), .REQ_ADDR(REQ_ADDR), .REQ_CODE(REQ_CODE),
      .REQ_WRITE(REQ_WRITE), .REQ_WDATA(REQ_WDATA), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID),
      .TGT_CODE(T_CODE), .TGT_RAM(T_RAM), .TGT_REGF(T_REGF), .TGT_BIT(T_BIT), .TGT_EXT(T_EXT),
      .TGT_ADDR(TGT_ADDR), .EXT_DONE(EXT_DONE), .EXT_RDATA(EXT_RDATA), .PC_INC(PC_INC),
      .PC_CUR(PC_CUR), .PC_NEXT(PC_NEXT), .LOW_ADDR_PORT_IN(LO_IN), .LOW_ADDR_PORT_OUT(LO_OUT),
      .LOW_ADDR_PORT_OE(LO_OE), .HIGH_ADDR_PORT_IN(HI_IN), .HIGH_ADDR_PORT_OUT(HI_OUT),
      .HIGH_ADDR_PORT_OE(HI_OE));
   msd_ext_mem_model u_msd_ext_mem_model (.clk(REF_CLK), .rst_n(RESET_N), .stall(stall),
      .low_out(LO_OUT), .low_oe(LO_OE), .high_out(HI_OUT), .high_oe(HI_OE), .low_in(LO_IN),
      .high_in(HI_IN), .wait_n(WAIT_N));

   // flags {code, ram, regf, bit, ext} then translated address
   function automatic logic [28:0] exp_dec(logic [23:0] a, logic code, logic onchip, logic map_n);
      logic [15:0] o;
      o = a[15:0];
      if (code)
         return (onchip && a[23:16] == 8'hff && !o[15]) ? {5'b10000, a} : {5'b00001, a};
      if (a[23:16] == 8'h00 && o < 16'h0020)
         return {5'b00100, a};
      if (a[23:16] == 8'h00 && o <= 16'h041f)
         return {2'b01, 1'b0, o <= 16'h00ff, 1'b0, a};
      if (a[23:16] == 8'h00 && o >= 16'hc000 && !map_n)
         return {onchip, 3'b000, !onchip, 10'h3fd, o[13:0]};
      return {5'b00001, a};
   endfunction

   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge REF_CLK);
      HADDR  <= a;
      HWRITE <= w;
      HTRANS <= 2'b10;
      do @(posedge REF_CLK); while (HREADY !== 1'b1);
      HTRANS <= 2'b00;
      HWDATA <= wd;
      do @(posedge REF_CLK); while (HREADY !== 1'b1);
      rd = HRDATA;
      chk("hresp", 32'h0, {31'h0, HRESP});
   endtask

   task automatic dec_chk(input logic code, input logic [23:0] a, input logic onchip, input logic map_n,
                          output int n);
      logic [28:0] e;
      logic [31:0] r;
      logic        w;
      e = exp_dec(a, code, onchip, map_n);
      r = $random(seed);
      w = !code && r[8];
      @(posedge REF_CLK);
      REQ_VALID <= 1'b1;
      REQ_ADDR  <= a;
      REQ_CODE  <= code;
      REQ_WRITE <= w;
      REQ_WDATA <= r[7:0];
      n = 0;
      do begin @(posedge REF_CLK); n++; end while (REQ_READY !== 1'b1 && n < 50);
      REQ_VALID <= 1'b0;
      #1;
      chk("rsp_valid", 32'h1, {31'h0, RSP_VALID});
      chk("req_ready", 32'h0, {31'h0, REQ_READY});
      chk("target", {3'b0, e}, {3'b0, T_CODE, T_RAM, T_REGF, T_BIT, T_EXT, TGT_ADDR});
      chk("tgt_ext", {31'h0, e[24]}, {31'h0, T_EXT});
      n = 0;
      if (e[24])
      begin
         do begin @(posedge REF_CLK); #1; n++; end while (EXT_DONE !== 1'b1 && n < 60);
         chk("ext_done", 32'h1, {31'h0, EXT_DONE});
         if (!w)
            chk("ext_rdata", {24'h0, e[7:0] ^ e[15:8] ^ 8'h5a}, {24'h0, EXT_RDATA});
      end
   endtask

   task automatic pc_chk(input logic [23:0] cur, input logic [23:0] e);
      @(posedge REF_CLK);
      PC_CUR <= cur;
      PC_INC <= 1'b1;
      @(posedge REF_CLK);
      PC_INC <= 1'b0;
      #1 chk("pc_next", {8'h0, e}, {8'h0, PC_NEXT});
   endtask

   initial
   begin
      REF_CLK = 1'b0;
      forever #2.5 REF_CLK = ~REF_CLK;
   end

   initial
   begin
      repeat (40000) @(posedge REF_CLK);
      n_errors++;
      report_and_stop();
   end

   initial
   begin
      logic [31:0] d, r;
      logic [23:0] a;
      logic        code, onchip, map_n, page, p;
      int          n;
      seed = 32'h910c;
      {HSEL, HADDR, HTRANS, HWRITE, HWDATA, HSIZE} = {1'b1, 32'h0, 2'b00, 1'b0, 32'h0, 3'b010};
      {REQ_VALID, REQ_ADDR, REQ_CODE, REQ_WRITE, REQ_WDATA} = '0;
      {PC_INC, PC_CUR, EXT_SEL_N, stall, RESET_N} = '0;
      repeat (5) @(posedge REF_CLK);
      chk("pc_reset", 32'hff0000, {8'h0, PC_NEXT});
      RESET_N <= 1'b1;
      repeat (2) @(posedge REF_CLK);
      ahb(1'b0, 32'h000, 32'h0, d); chk("cfg_reset", 32'h0, d);
      ahb(1'b0, 32'h29c, 32'h0, d); chk("wait_ctl_reset", 32'h0, d);
      ahb(1'b1, 32'h100, 32'hffffffff, d);
      ahb(1'b0, 32'h100, 32'h0, d); chk("unmapped", 32'h0, d);
      ahb(1'b1, 32'h29c, 32'h3, d);
      ahb(1'b0, 32'h29c, 32'h0, d); chk("wait_ctl_rw", 32'h3, d);
      ahb(1'b1, 32'h29c, 32'h0, d);
      for (int m = 0; m < 4; m++)
      begin
         {map_n, onchip} = m[1:0];
         r = $random(seed);
         page = r[0];
         EXT_SEL_N <= onchip;
         ahb(1'b1, 32'h000, {30'h0, page, map_n}, d);
         repeat (3) @(posedge REF_CLK);
         ahb(1'b0, 32'h004, 32'h0, d); chk("status", {31'h0, onchip}, d);
         for (int i = 0; i < 20; i++)
         begin
            r = $random(seed);
            {code, a} = (i < 13) ? corner[i] : {r[31], segs[r[25:24]], r[15:0]};
            if (!code && a[23:16] == 8'hff)
               a[23:16] = 8'h00;
            dec_chk(code, a, onchip, map_n, n);
            if (n != 0)
               chk("ext_cycles", 32'd5, n);
         end
      end
      ahb(1'b1, 32'h29c, 32'h1, d);
      stall <= 4'h6;
      dec_chk(1'b0, 24'h010010, 1'b1, 1'b1, n);
      chk("stretched", 32'd11, n);
      stall <= 4'h0;
      dec_chk(1'b0, 24'hfe1234, 1'b1, 1'b1, n);
      chk("ready_cycles", 32'd5, n);
      ahb(1'b1, 32'h29c, 32'h2, d);
      repeat (3) @(posedge REF_CLK);
      #1 p = WAIT_CLK;
      repeat (8)
      begin
         @(posedge REF_CLK);
         #1 chk("wait_clk", {31'h0, ~p}, {31'h0, WAIT_CLK});
         p = WAIT_CLK;
      end
      ahb(1'b1, 32'h29c, 32'h0, d);
      repeat (3) @(posedge REF_CLK);
      #1 chk("wait_clk_off", 32'h0, {31'h0, WAIT_CLK});
      pc_chk(24'hffffff, 24'hff0000);
      pc_chk(24'hfeffff, 24'hff0000);
      pc_chk(24'h01ffff, 24'h000000);
      repeat (8)
      begin
         r = $random(seed);
         a = {segs[r[25:24]], r[15:0] & 16'hfffe};
         pc_chk(a, a + 24'h1);
      end
      report_and_stop();
   end
endmodule
